// *** core/cds_pkg.sv ***
package cds_pkg;
    // register byte offsets on the apb side
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_TXD = 8'h08;
    localparam logic [7:0] OFS_RXD = 8'h0C;
    localparam logic [7:0] OFS_WP0 = 8'h10;
    localparam logic [7:0] OFS_WP1 = 8'h20;
    localparam logic [7:0] OFS_END = 8'h30;
    // control register fields
    localparam int CTRL_EXTERNAL_DEBUG_REQ = 1;
    localparam int CTRL_WPEN0 = 4;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    // status register fields
    localparam int ST_RXF = 0;
    localparam int ST_TXE = 1;
    localparam int ST_ACK = 2;
    localparam int ST_ISA = 3;
    localparam int ST_WPH0 = 4;
    localparam int ST_WPA0 = 6;
    localparam int ST_SCN = 8;
    localparam int ST_MODE = 16;
    // synchroniser vector layout
    localparam int PS_DBG = 0;
    localparam int PS_TCK = 1;
    localparam int PS_TRST = 2;
    localparam int PS_UPD = 3;
    localparam int PS_SHF = 4;
    localparam int PS_INS = 5;
    localparam int PS_SCN = 9;
    localparam int PS_W = 13;
    // resting level of the synchronised pins
    localparam logic [12:0] PS_RST = 13'h0000;
    // one watchpoint's comparison set
    typedef struct packed {
        logic [31:0] av;
        logic [31:0] am;
        logic [31:0] dv;
        logic [31:0] dm;
    } cds_wp_t;
    // watched bus sample
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
    } cds_bus_t;
    // coprocessor handshake states
    typedef enum logic [2:0] {
        CP_IDLE = 3'b001,
        CP_REQ = 3'b010,
        CP_WAIT = 3'b100
    } cds_cp_t;
endpackage

// *** core/cds_sideband.sv ***
`timescale 1ns/1ps
module cds_sideband
    import cds_pkg::*;
#(
    parameter logic [3:0] TRISTATE_INSTR_ACTIVE_CODE = 4'h7
) (
    input wire logic CLK_SYS_IN,
    input wire logic RSTN_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    input wire logic RX_LOAD_IN,
    input wire logic [31:0] RX_DATA_IN,
    input wire logic TX_TAKE_IN,
    output logic [31:0] TX_DATA_OUT,
    input wire logic DEBUG_STATE_IN,
    input wire logic EXT_DEBUG_REQ_IN,
    input wire logic [31:0] WATCH_ADDR_IN,
    input wire logic [31:0] WATCH_DATA_IN,
    input wire logic CP_START_IN,
    input wire logic COPROC_ABSENT_IN,
    input wire logic COPROC_BUSY_IN,
    input wire logic WRITE_CYCLE_IN,
    input wire logic EXEC_FAIL_IN,
    input wire logic [4:0] MODE_IN,
    input wire logic BX_EXEC_IN,
    input wire logic TESTER_TAP_RESET_N_IN,
    input wire logic TESTER_TAP_CLOCK_IN,
    input wire logic TAP_UPDATE_DR_IN,
    input wire logic TAP_SHIFT_DR_IN,
    input wire logic [3:0] TAP_INSTR_IN,
    input wire logic [3:0] TAP_SCAN_NUM_IN,
    output logic COMM_RX_FULL_OUT,
    output logic COMM_TX_EMPTY_OUT,
    output logic DEBUG_ACK_OUT,
    output logic INTERNAL_DEBUG_REQ_OUT,
    output logic TRISTATE_INSTR_ACTIVE_OUT,
    output logic [1:0] WATCHPOINT_MATCH_OUT,
    output logic COPROC_INSTR_N_OUT,
    output logic CP_UNDEF_OUT,
    output logic CP_DONE_OUT,
    output logic WRITE_DRIVE_EN_N_OUT,
    output logic WRITE_DRIVE_EN_INT_N_OUT,
    output logic NOT_EXECUTED_OUT,
    output logic [4:0] PROC_MODE_INV_OUT,
    output logic SERIAL_OUT_EN_N_OUT,
    output logic [3:0] SCAN_CHAIN_SEL_OUT,
    output logic COMPACT_ISA_STATE_OUT,
    output logic TESTER_TAP_RESET_N_OUT,
    output logic TESTER_TAP_CLOCK_OUT
);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // masked compare: a set mask bit means do not care
    function automatic logic wp_hit(input cds_wp_t c, input cds_bus_t b);
        wp_hit = (((b.addr ^ c.av) & ~c.am) == 32'h0000_0000) &&
                 (((b.data ^ c.dv) & ~c.dm) == 32'h0000_0000);
    endfunction

    // true when the address lies in the 16-byte window of the watchpoint set at base
    function automatic logic wp_sel(input logic [7:0] a, input logic [7:0] base);
        wp_sel = (a >= base) && (a < base + 8'h10);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic [12:0] pin_raw; // pins from outside this clock
    logic [12:0] s1_q; // first stage, read by s2 only
    logic [12:0] s2_q;
    logic [12:0] s3_q;
    logic [12:0] flt_q; // accepted level per bit
    logic tck_prev_q; // last accepted tester clock
    logic tck_fall; // one-cycle enable on tck fall

    assign pin_raw = {TAP_SCAN_NUM_IN, TAP_INSTR_IN, TAP_SHIFT_DR_IN,
                      TAP_UPDATE_DR_IN, TESTER_TAP_RESET_N_IN,
                      TESTER_TAP_CLOCK_IN, EXT_DEBUG_REQ_IN};

    // three flops; a bit is accepted once stages two and three agree
    always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            s1_q <= PS_RST;
            s2_q <= PS_RST;
            s3_q <= PS_RST;
        end else begin
            s1_q <= pin_raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // per-bit filter; a lone glitch never reaches the logic
    genvar gi;
    generate
        for (gi = 0; gi < PS_W; gi++) begin : g_flt
            always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
                if (!RSTN_IN) begin
                    flt_q[gi] <= PS_RST[gi];
                end else if (s2_q[gi] == s3_q[gi]) begin
                    flt_q[gi] <= s3_q[gi];
                end
            end
        end
    endgenerate

    // tester clock edge history; the system clock must be well above it
    always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            tck_prev_q <= 1'b0;
        end else begin
            tck_prev_q <= flt_q[PS_TCK];
        end
    end

    assign tck_fall = tck_prev_q & ~flt_q[PS_TCK];

    ////////////////////////////////////////////////////////////////////////
    // apb slave and registers

    logic [31:0] ctrl_q; // debug control register
    logic [31:0] txd_q; // transmit word
    logic [31:0] rxd_q; // receive word
    logic rx_full_q;
    logic tx_full_q;
    cds_wp_t wp_q [2]; // watchpoint sets, by index
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic acc_done; // access completes this edge
    logic wr_en;
    logic rd_en;
    logic sel_wp0;
    logic sel_wp1;
    logic addr_ok;
    logic [31:0] stat_w; // live status word
    logic [31:0] rd_mux; // read data for the address
    logic [31:0] wp_word [2]; // selected field of each set
    logic [1:0] hit_w; // raw comparator results

    assign acc_done = PSEL_IN & PENABLE_IN & pready_q;
    assign wr_en = acc_done & PWRITE_IN & addr_ok;
    assign rd_en = acc_done & ~PWRITE_IN & addr_ok;
    assign sel_wp0 = wp_sel(PADDR_IN, OFS_WP0);
    assign sel_wp1 = wp_sel(PADDR_IN, OFS_WP1);
    // only aligned words inside the map answer without error
    assign addr_ok = (PADDR_IN[1:0] == 2'h0) && (PADDR_IN < OFS_END);

    // field within a set chosen by word offset
    generate
        for (gi = 0; gi < 2; gi++) begin : g_wpw
            assign wp_word[gi] = (PADDR_IN[3:2] == 2'h0) ? wp_q[gi].av :
                                 (PADDR_IN[3:2] == 2'h1) ? wp_q[gi].am :
                                 (PADDR_IN[3:2] == 2'h2) ? wp_q[gi].dv :
                                 wp_q[gi].dm;
        end
    endgenerate

    // status word shows the block's own state
    assign stat_w = {11'h000, ~PROC_MODE_INV_OUT, 4'h0, SCAN_CHAIN_SEL_OUT,
                     ctrl_q[CTRL_WPEN0 +: 2] & WATCHPOINT_MATCH_OUT,
                     WATCHPOINT_MATCH_OUT, COMPACT_ISA_STATE_OUT,
                     DEBUG_ACK_OUT, ~tx_full_q, rx_full_q};

    assign rd_mux = (PADDR_IN == OFS_CTRL) ? ctrl_q :
                    (PADDR_IN == OFS_STAT) ? stat_w :
                    (PADDR_IN == OFS_TXD) ? txd_q :
                    (PADDR_IN == OFS_RXD) ? rxd_q :
                    sel_wp0 ? wp_word[0] :
                    sel_wp1 ? wp_word[1] : 32'h0000_0000;

    // ready one cycle into access: no wait states, and never twice
    always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= PSEL_IN & ~PENABLE_IN;
            pslverr_q <= PSEL_IN & ~PENABLE_IN & ~addr_ok;
            prdata_q <= (PSEL_IN & ~PENABLE_IN & ~PWRITE_IN) ? rd_mux : 32'h0000_0000;
        end
    end

    // control and transmit word writes
    always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            ctrl_q <= CTRL_RST;
            txd_q <= 32'h0000_0000;
        end else if (wr_en) begin
            if (PADDR_IN == OFS_CTRL) begin
                ctrl_q <= PWDATA_IN;
            end
            if (PADDR_IN == OFS_TXD) begin
                txd_q <= PWDATA_IN;
            end
        end
    end

    // watchpoint set writes, one loop for both units
    generate
        for (gi = 0; gi < 2; gi++) begin : g_wpr
            logic hit_sel;
            assign hit_sel = (gi == 0) ? sel_wp0 : sel_wp1;
            always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
                if (!RSTN_IN) begin
                    wp_q[gi] <= '0;
                end else if (wr_en && hit_sel) begin
                    case (PADDR_IN[3:2])
                        2'h0: wp_q[gi].av <= PWDATA_IN;
                        2'h1: wp_q[gi].am <= PWDATA_IN;
                        2'h2: wp_q[gi].dv <= PWDATA_IN;
                        default: wp_q[gi].dm <= PWDATA_IN;
                    endcase
                end
            end
            // comparator; the enable bit only colours the status word
            assign hit_w[gi] = wp_hit(wp_q[gi], {WATCH_ADDR_IN, WATCH_DATA_IN});
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // communications channel

    // rx: load sets, software read clears; the load wins a tie
    always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            rx_full_q <= 1'b0;
            rxd_q <= 32'h0000_0000;
        end else if (RX_LOAD_IN) begin
            rx_full_q <= 1'b1;
            rxd_q <= RX_DATA_IN;
        end else if (rd_en && PADDR_IN == OFS_RXD) begin
            rx_full_q <= 1'b0;
        end
    end

    // tx: software write fills, far side take empties; write wins
    always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            tx_full_q <= 1'b0;
        end else if (wr_en && PADDR_IN == OFS_TXD) begin
            tx_full_q <= 1'b1;
        end else if (TX_TAKE_IN) begin
            tx_full_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // coprocessor handshake

    cds_cp_t cp_q;
    cds_cp_t cp_d;
    logic cp_undef_d;
    logic cp_done_d;

    // strobe, then sample absent once, then wait on busy
    always_comb begin
        cp_d = cp_q;
        cp_undef_d = 1'b0;
        cp_done_d = 1'b0;
        case (cp_q)
            CP_IDLE: begin
                if (CP_START_IN) begin
                    cp_d = CP_REQ;
                end
            end
            CP_REQ: begin
                if (COPROC_ABSENT_IN) begin
                    cp_d = CP_IDLE;
                    cp_undef_d = 1'b1;
                end else if (!COPROC_BUSY_IN) begin
                    cp_d = CP_IDLE;
                    cp_done_d = 1'b1;
                end else begin
                    cp_d = CP_WAIT;
                end
            end
            CP_WAIT: begin
                if (!COPROC_BUSY_IN) begin
                    cp_d = CP_IDLE;
                    cp_done_d = 1'b1;
                end
            end
            default: cp_d = CP_IDLE;
        endcase
    end

    // replies are taken as same-clock levels, no synchroniser
    always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            cp_q <= CP_IDLE;
            COPROC_INSTR_N_OUT <= 1'b1;
            CP_UNDEF_OUT <= 1'b0;
            CP_DONE_OUT <= 1'b0;
        end else begin
            cp_q <= cp_d;
            COPROC_INSTR_N_OUT <= (cp_d == CP_IDLE);
            CP_UNDEF_OUT <= cp_undef_d;
            CP_DONE_OUT <= cp_done_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // core status outputs, all on the system clock

    always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            COMM_RX_FULL_OUT <= 1'b0;
            COMM_TX_EMPTY_OUT <= 1'b1;
            DEBUG_ACK_OUT <= 1'b0;
            INTERNAL_DEBUG_REQ_OUT <= 1'b0;
            TRISTATE_INSTR_ACTIVE_OUT <= 1'b0;
            WATCHPOINT_MATCH_OUT <= 2'h0;
            WRITE_DRIVE_EN_N_OUT <= 1'b1;
            WRITE_DRIVE_EN_INT_N_OUT <= 1'b1;
            NOT_EXECUTED_OUT <= 1'b0;
            PROC_MODE_INV_OUT <= 5'h1F;
            TESTER_TAP_RESET_N_OUT <= 1'b0;
            TESTER_TAP_CLOCK_OUT <= 1'b0;
        end else begin
            COMM_RX_FULL_OUT <= rx_full_q;
            COMM_TX_EMPTY_OUT <= ~tx_full_q;
            DEBUG_ACK_OUT <= DEBUG_STATE_IN;
            INTERNAL_DEBUG_REQ_OUT <= flt_q[PS_DBG] | ctrl_q[CTRL_EXTERNAL_DEBUG_REQ];
            TRISTATE_INSTR_ACTIVE_OUT <= (flt_q[PS_INS +: 4] == TRISTATE_INSTR_ACTIVE_CODE);
            WATCHPOINT_MATCH_OUT <= hit_w;
            WRITE_DRIVE_EN_N_OUT <= ~WRITE_CYCLE_IN;
            WRITE_DRIVE_EN_INT_N_OUT <= ~WRITE_CYCLE_IN;
            NOT_EXECUTED_OUT <= EXEC_FAIL_IN;
            PROC_MODE_INV_OUT <= ~MODE_IN;
            TESTER_TAP_RESET_N_OUT <= flt_q[PS_TRST];
            TESTER_TAP_CLOCK_OUT <= flt_q[PS_TCK];
        end
    end

    // isa state flips on every cycle that BX_EXEC_IN is high, with no edge detection
    always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            COMPACT_ISA_STATE_OUT <= 1'b0;
        end else if (BX_EXEC_IN) begin
            COMPACT_ISA_STATE_OUT <= ~COMPACT_ISA_STATE_OUT;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // tap-timed outputs, moved on tester clock falls or forced to rest by tap reset

    // tap reset clears the chain number; shift state sets enable
    always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            SCAN_CHAIN_SEL_OUT <= 4'h0;
            SERIAL_OUT_EN_N_OUT <= 1'b1;
        end else if (!flt_q[PS_TRST]) begin
            SCAN_CHAIN_SEL_OUT <= 4'h0;
            SERIAL_OUT_EN_N_OUT <= 1'b1;
        end else if (tck_fall) begin
            if (flt_q[PS_UPD]) begin
                SCAN_CHAIN_SEL_OUT <= flt_q[PS_SCN +: 4];
            end
            SERIAL_OUT_EN_N_OUT <= ~flt_q[PS_SHF];
        end
    end

    assign PRDATA_OUT = prdata_q;
    assign PREADY_OUT = pready_q;
    assign PSLVERR_OUT = pslverr_q;
    assign TX_DATA_OUT = txd_q;

    ////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (!RSTN_IN);

    sequence s_cp_start;
        cp_q == CP_IDLE && CP_START_IN;
    endsequence

    sequence s_cp_absent;
        cp_q == CP_REQ && COPROC_ABSENT_IN;
    endsequence

    a_rx_load_full: assert property (RX_LOAD_IN |=> ##1 COMM_RX_FULL_OUT)
        else $error("rx full not raised after load");
    a_tx_write_empty: assert property (
        (wr_en && PADDR_IN == OFS_TXD) |=> ##1 !COMM_TX_EMPTY_OUT)
        else $error("tx empty not cleared by write");
    a_debug_ack_follow: assert property (DEBUG_STATE_IN |=> DEBUG_ACK_OUT)
        else $error("debug ack does not follow state");
    a_dbg_req_ctrl: assert property (
        ctrl_q[CTRL_EXTERNAL_DEBUG_REQ] |=> INTERNAL_DEBUG_REQ_OUT)
        else $error("internal request ignores ctrl bit");
    // the reset edge itself is skipped: the flops hold zero while the raw compare may hit
    a_wp_match_raw: assert property (
        $past(RSTN_IN) |-> WATCHPOINT_MATCH_OUT == $past(hit_w))
        else $error("watchpoint output not raw match");
    a_cp_strobe_low: assert property (s_cp_start |=> !COPROC_INSTR_N_OUT)
        else $error("coproc strobe not driven low");
    a_cp_abort_undef: assert property (
        s_cp_absent |=> CP_UNDEF_OUT && COPROC_INSTR_N_OUT)
        else $error("absent coprocessor not aborted");
    a_cp_wait_busy: assert property (
        (cp_q == CP_WAIT && COPROC_BUSY_IN) |=> !COPROC_INSTR_N_OUT && !CP_DONE_OUT)
        else $error("busy wait left early");
    a_write_en_pair: assert property (
        WRITE_CYCLE_IN |=> !WRITE_DRIVE_EN_N_OUT && !WRITE_DRIVE_EN_INT_N_OUT)
        else $error("write enables not low");
    a_mode_inverse: assert property (
        $past(RSTN_IN) |-> PROC_MODE_INV_OUT == ~$past(MODE_IN))
        else $error("mode output not inverted");
    a_scan_on_fall: assert property (
        $changed(SCAN_CHAIN_SEL_OUT) |-> $past(tck_fall) || !$past(flt_q[PS_TRST]))
        else $error("scan number moved off tck fall");
    a_isa_toggle: assert property (
        BX_EXEC_IN |=> COMPACT_ISA_STATE_OUT != $past(COMPACT_ISA_STATE_OUT))
        else $error("isa state did not toggle");

endmodule

// *** tb/cds_cp_model.sv ***
`timescale 1ns/1ps
// coprocessor stand-in: answers the strobe with absent and busy levels
module cds_cp_model (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic strobe_n_in,
    input wire logic absent_mode_in,
    input wire logic [3:0] wait_in,
    output logic absent_out,
    output logic busy_out
);
    logic [3:0] cnt_q; // cycles spent in the current request
    ////////////////////////////////////////////////////////////////
    // count while the strobe is low; saturate so a stuck strobe cannot wrap
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cnt_q <= 4'h0;
        end else if (strobe_n_in) begin
            cnt_q <= 4'h0;
        end else if (cnt_q != 4'hF) begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
    // both levels move only just after an edge, so they are stable at the next
    assign absent_out = absent_mode_in;
    assign busy_out = strobe_n_in ? 1'b1 : (cnt_q < wait_in);
endmodule

// *** tb/cds_sideband_tb.sv ***
`timescale 1ns/1ps
module cds_sideband_tb;
    import cds_pkg::*;
    localparam logic [3:0] hz = 4'h7; // tristate instruction code
    logic clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, rxl = 0, txt = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rxd = 32'h0, wa = 32'h0, wd = 32'h0, prdata, txo, rdat;
    logic pready, pslverr, rerr, dbg = 0, ext = 0, cps = 0, coproc_absent, coproc_busy, wrc = 0, fail = 0;
    logic bx = 0, trst = 0, tck = 0, upd = 0, shf = 0, cpam = 0;
    logic [3:0] ins = 4'h0, scn = 4'h0, cpw = 4'h0, sel;
    logic [4:0] mode = 5'h00, mdi;
    logic rxf, txe, ack, idr, tri_on, cpn, cpu, cpd, en_n, eni_n, nex, soe, isa, trst_o, tck_o;
    logic [1:0] wpm;
    int miscompares = 0, samples_checked = 0;
    // free-running system clock, 8 ns
    always #4 clk = ~clk;
    cds_sideband #(.TRISTATE_INSTR_ACTIVE_CODE(hz)) dut (.CLK_SYS_IN(clk), .RSTN_IN(rstn), .PSEL_IN(psel),
        .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
        .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .RX_LOAD_IN(rxl),
        .RX_DATA_IN(rxd), .TX_TAKE_IN(txt), .TX_DATA_OUT(txo), .DEBUG_STATE_IN(dbg),
        .EXT_DEBUG_REQ_IN(ext), .WATCH_ADDR_IN(wa), .WATCH_DATA_IN(wd), .CP_START_IN(cps),
        .COPROC_ABSENT_IN(coproc_absent), .COPROC_BUSY_IN(coproc_busy), .WRITE_CYCLE_IN(wrc),
        .EXEC_FAIL_IN(fail), .MODE_IN(mode), .BX_EXEC_IN(bx), .TESTER_TAP_RESET_N_IN(trst),
        .TESTER_TAP_CLOCK_IN(tck), .TAP_UPDATE_DR_IN(upd), .TAP_SHIFT_DR_IN(shf),
        .TAP_INSTR_IN(ins), .TAP_SCAN_NUM_IN(scn), .COMM_RX_FULL_OUT(rxf),
        .COMM_TX_EMPTY_OUT(txe), .DEBUG_ACK_OUT(ack), .INTERNAL_DEBUG_REQ_OUT(idr),
        .TRISTATE_INSTR_ACTIVE_OUT(tri_on), .WATCHPOINT_MATCH_OUT(wpm),
        .COPROC_INSTR_N_OUT(cpn), .CP_UNDEF_OUT(cpu), .CP_DONE_OUT(cpd),
        .WRITE_DRIVE_EN_N_OUT(en_n), .WRITE_DRIVE_EN_INT_N_OUT(eni_n),
        .NOT_EXECUTED_OUT(nex), .PROC_MODE_INV_OUT(mdi), .SERIAL_OUT_EN_N_OUT(soe),
        .SCAN_CHAIN_SEL_OUT(sel), .COMPACT_ISA_STATE_OUT(isa),
        .TESTER_TAP_RESET_N_OUT(trst_o), .TESTER_TAP_CLOCK_OUT(tck_o));
    cds_cp_model cp (.clk_in(clk), .rstn_in(rstn), .strobe_n_in(cpn), .absent_mode_in(cpam),
        .wait_in(cpw), .absent_out(coproc_absent), .busy_out(coproc_busy));
    ////////////////////////////////////////////////////////////////
    // value comparison, counted
    task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task cyc(input int k);
        repeat (k) @(posedge clk);
    endtask
    // one apb transfer; request held until pready is seen at an edge
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1; pen <= 1'b0; pwr <= wr; paddr <= a; pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rdat = prdata;
        rerr = pslverr;
        if (n >= 16) chk(0, 1, "apb no ready");
        psel <= 1'b0; pen <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////
    // plain level inputs reach their outputs; en_n pair must agree
    task t_status;
        @(posedge clk);
        mode <= 5'h13; fail <= 1'b1; wrc <= 1'b1; dbg <= 1'b1;
        cyc(3);
        chk(mdi, 5'h0C, "mode inverse");
        chk(nex, 1, "not executed");
        chk({en_n, eni_n}, 0, "write enables");
        chk(ack, 1, "debug ack");
        fail <= 1'b0; wrc <= 1'b0; dbg <= 1'b0;
        cyc(3);
        chk({nex, en_n, eni_n, ack}, 4'h6, "status idle");
        $display("test status done");
    endtask
    // request from control bit 1 and from the pin, plus refused addresses
    task t_dbgreq;
        apb(1, OFS_CTRL, 32'h0000_0002);
        cyc(2);
        chk(idr, 1, "req from ctrl");
        apb(1, OFS_CTRL, 32'h0000_0000);
        ext <= 1'b1;
        cyc(8);
        chk(idr, 1, "req from pin");
        ext <= 1'b0;
        cyc(8);
        chk(idr, 0, "req idle");
        apb(0, OFS_END, 32'h0);
        chk(rerr, 1, "unmapped");
        apb(0, 8'h02, 32'h0);
        chk(rerr, 1, "unaligned");
        $display("test dbgreq done");
    endtask
    // receive flag two edges after load, cleared by read; transmit flag
    task t_comm;
        @(posedge clk);
        rxl <= 1'b1; rxd <= 32'hA5A5_0001;
        @(posedge clk);
        rxl <= 1'b0;
        #1 chk(rxf, 0, "rx early");
        @(posedge clk);
        #1 chk(rxf, 1, "rx full");
        apb(0, OFS_RXD, 32'h0);
        chk(rdat, 32'hA5A5_0001, "rx word");
        cyc(3);
        chk(rxf, 0, "rx cleared");
        apb(1, OFS_TXD, 32'h1234_5678);
        cyc(3);
        chk({txe, txo}, {1'b0, 32'h1234_5678}, "tx loaded");
        txt <= 1'b1;
        @(posedge clk);
        txt <= 1'b0;
        cyc(3);
        chk(txe, 1, "tx empty");
        $display("test comm done");
    endtask
    // watchpoints with enables left clear; data ignored by mask
    task t_wp;
        for (int i = 0; i < 2; i++) begin
            apb(1, OFS_WP0 + 8'(i * 16), 32'h0000_1000 + 32'(i) * 32'h1000);
            apb(1, OFS_WP0 + 8'(i * 16 + 4), 32'h0);
            apb(1, OFS_WP0 + 8'(i * 16 + 8), 32'h0);
            apb(1, OFS_WP0 + 8'(i * 16 + 12), 32'hFFFF_FFFF);
        end
        wa <= 32'h0000_1000; wd <= 32'hDEAD_0055;
        cyc(3);
        chk(wpm, 2'b01, "unit 0 match");
        wa <= 32'h0000_2000;
        cyc(3);
        chk(wpm, 2'b10, "unit 1 match");
        wa <= 32'h0000_3000;
        cyc(3);
        chk(wpm, 2'b00, "no match");
        $display("test watchpoint done");
    endtask
    // absent, present with no wait, present with busy wait
    task t_cp;
        logic [4:0] tab [3];
        logic lo, u, dn;
        int n;
        tab = '{5'h10, 5'h00, 5'h03};
        foreach (tab[k]) begin
            @(posedge clk);
            cpam <= tab[k][4]; cpw <= tab[k][3:0]; cps <= 1'b1;
            @(posedge clk);
            cps <= 1'b0;
            // the strobe may stand for one cycle only, so look right after the taking edge
            #1;
            lo = (cpn === 1'b0);
            u = 0;
            dn = 0;
            for (n = 0; n < 20 && !(u || dn); n++) begin
                @(posedge clk);
                #1;
                if (cpn === 1'b0) lo = 1;
                if (cpu === 1'b1) u = 1;
                if (cpd === 1'b1) dn = 1;
            end
            chk(lo, 1, "strobe low");
            chk(u, tab[k][4], "undef");
            chk(dn, !tab[k][4], "done");
            if (!tab[k][4]) chk(n > tab[k][3:0], 1, "busy wait");
            cyc(2);
            chk(cpn, 1, "strobe released");
        end
        $display("test coproc done");
    endtask
    // branch exchange toggles the compact flag
    task t_isa;
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            bx <= 1'b1;
            @(posedge clk);
            bx <= 1'b0;
            cyc(2);
            chk(isa, 1 - i, "isa flag");
        end
        $display("test isa done");
    endtask
    // slow tester clock; scan number only moves on a fall in update
    task t_tap;
        trst <= 1'b1; ins <= hz; upd <= 1'b1; shf <= 1'b1; scn <= 4'h5;
        cyc(8);
        chk({trst_o, tri_on}, 2'b11, "tap reset, tristate");
        tck <= 1'b1;
        cyc(8);
        chk({tck_o, sel}, {1'b1, 4'h0}, "before fall");
        tck <= 1'b0;
        cyc(8);
        chk({sel, soe}, {4'h5, 1'b0}, "after fall");
        upd <= 1'b0; shf <= 1'b0; scn <= 4'h9; ins <= 4'h0;
        tck <= 1'b1;
        cyc(8);
        tck <= 1'b0;
        cyc(8);
        chk({sel, soe, tri_on}, {4'h5, 2'b10}, "no update");
        $display("test tap done");
    endtask
    ////////////////////////////////////////////////////////////////
    task end_sim;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        cyc(10);
        rstn <= 1'b1;
        cyc(2);
        chk({txe, rxf, cpn, en_n, pready}, 5'h16, "reset levels");
        t_status;
        t_dbgreq;
        t_comm;
        t_wp;
        t_cp;
        t_isa;
        t_tap;
        end_sim;
    end
    // watchdog, well past the expected run
    initial begin
        #200000;
        miscompares++;
        end_sim;
    end
endmodule
